// ===== clk_out_pkg.sv
// Package: constants, field layouts and encodings for the clock output control block.
// Assumes a single 50 MHz system clock and a synchronous active-high reset.
package clk_out_pkg;
	localparam int NUM_OUTPUTS = 4;
	localparam int PHASE_W = 8;
	localparam int DIV_W = 8;
	localparam int NVM_WORDS = 8;
	localparam int NVM_W = 16;
	localparam int PAGE_SIZE = 256;
	localparam logic [7:0] HOME_PAGE = 8'h00;
	// Drive select codes; code 1 is the weakest setting
	localparam logic [1:0] DRV_WEAK = 2'h1;
	localparam logic [1:0] DRV_MID = 2'h2;
	localparam logic [1:0] DRV_STRONG = 2'h3;
	localparam logic [1:0] DRV_RESET = 2'h3;
	// Driver supply rail codes
	localparam logic [1:0] RAIL_3V3 = 2'h0;
	localparam logic [1:0] RAIL_2V5 = 2'h1;
	localparam logic [1:0] RAIL_1V8 = 2'h2;
	// Zero-delay minimum input clock rate
	localparam int ZD_MIN_KHZ = 128;
	// Non-volatile store write budget
	localparam logic [1:0] NVM_MAX_WRITES = 2'h2;
	// Default divider reload value
	localparam logic [DIV_W-1:0] DIV_RESET = 8'h01;
	// Host port modes
	localparam logic HOST_I2C = 1'b1;
	localparam logic HOST_SPI = 1'b0;
	typedef enum logic [3:0] {
		ST_RESET = 4'b0001,
		ST_LOAD = 4'b0010,
		ST_DIVRST = 4'b0100,
		ST_RUN = 4'b1000
	} init_state_e;
endpackage

// ===== out_driver_gate.sv
// Output driver gating for one clock output: disable, park level, polarity, drive select.
// Assumes the divided clock level arrives as a synchronous level on the system clock.
`timescale 1ns/10ps
module out_driver_gate
	import clk_out_pkg::*;
(
	input  wire logic       ref_clk_in,
	input  wire logic       rst_in,
	input  wire logic       clk_level_in,
	input  wire logic       disable_in,
	input  wire logic       sync_disable_in,
	input  wire logic       park_high_in,
	input  wire logic       single_ended_in,
	input  wire logic       invert_true_in,
	input  wire logic       invert_comp_in,
	input  wire logic [1:0] drive_select_in,
	input  wire logic [1:0] rail_in,
	output logic            clock_out_true_pin_out,
	output logic            clock_out_comp_pin_out,
	output logic            driver_on_out,
	output logic [1:0]      drive_out
);
	logic on_reg;
	logic prev_level_reg;
	logic period_end;
	logic true_next;
	logic comp_next;
	// A falling edge of the clock closes one full period
	assign period_end = prev_level_reg & ~clk_level_in;
	always_ff @(posedge ref_clk_in)
	begin
		if (rst_in)
			prev_level_reg <= 1'b0;
		else
			prev_level_reg <= clk_level_in;
	end
	always_ff @(posedge ref_clk_in)
	begin
		if (rst_in)
			on_reg <= 1'b0;
		else if (!disable_in)
			on_reg <= 1'b1;
		else if (sync_disable_in)
		begin
			if (period_end || !clk_level_in)
				on_reg <= 1'b0;
		end
		else
			on_reg <= 1'b0;
	end
	always_comb
	begin
		true_next = clk_level_in ^ invert_true_in;
		comp_next = single_ended_in ? (clk_level_in ^ invert_comp_in)
			: ~(clk_level_in ^ invert_true_in);
		if (!on_reg)
		begin
			true_next = park_high_in;
			comp_next = single_ended_in ? park_high_in : ~park_high_in;
		end
	end
	always_ff @(posedge ref_clk_in)
	begin
		if (rst_in)
		begin
			clock_out_true_pin_out <= 1'b0;
			clock_out_comp_pin_out <= 1'b0;
		end
		else
		begin
			clock_out_true_pin_out <= true_next;
			clock_out_comp_pin_out <= comp_next;
		end
	end
	// weak code refused on low rail
	always_ff @(posedge ref_clk_in)
	begin
		if (rst_in)
			drive_out <= DRV_RESET;
		else if (rail_in == RAIL_1V8 && drive_select_in == DRV_WEAK)
			drive_out <= DRV_MID;
		else if (drive_select_in == 2'h0)
			drive_out <= DRV_RESET;
		else
			drive_out <= drive_select_in;
	end
	assign driver_on_out = on_reg;
	a_off_parks: assert property (p_off_parks) else $error("disabled output not parked");
	property p_off_parks;
		@(posedge ref_clk_in) disable iff (rst_in)
		!on_reg |=> (clock_out_true_pin_out == $past(park_high_in));
	endproperty
	a_async_off: assert property (p_async_off) else $error("immediate disable late");
	property p_async_off;
		@(posedge ref_clk_in) disable iff (rst_in)
		(disable_in && !sync_disable_in) |=> !on_reg;
	endproperty
	a_sync_hold: assert property (p_sync_hold) else $error("sync disable cut a high phase");
	property p_sync_hold;
		@(posedge ref_clk_in) disable iff (rst_in)
		(on_reg && disable_in && sync_disable_in && clk_level_in && prev_level_reg) |=> on_reg;
	endproperty
	a_drive: assert property (p_drive) else $error("weak drive on low rail");
	property p_drive;
		@(posedge ref_clk_in) disable iff (rst_in)
		(rail_in == RAIL_1V8) |=> (drive_out != DRV_WEAK);
	endproperty
endmodule

// ===== clock_output_gating_control.sv
// Clock output gating control: power-up sequencing, output dividers, gating and host settings.
// Assumes all inputs except global_output_disable_pin_in synchronous to ref_clk_in; the serial host port sits outside this block.
`timescale 1ns/10ps
module clock_output_gating_control
	import clk_out_pkg::*;
(
	input  wire logic                           ref_clk_in,
	input  wire logic                           rst_in,
	input  wire logic                           global_output_disable_pin_in,
	input  wire logic [NUM_OUTPUTS-1:0]         out_disable_in,
	input  wire logic [NUM_OUTPUTS-1:0]         sync_disable_in,
	input  wire logic [NUM_OUTPUTS-1:0]         park_high_in,
	input  wire logic [NUM_OUTPUTS-1:0]         single_ended_in,
	input  wire logic [NUM_OUTPUTS-1:0]         invert_true_in,
	input  wire logic [NUM_OUTPUTS-1:0]         invert_comp_in,
	input  wire logic [2*NUM_OUTPUTS-1:0]       single_ended_drive_select_in,
	input  wire logic [2*NUM_OUTPUTS-1:0]       driver_supply_rail_in,
	input  wire logic [DIV_W*NUM_OUTPUTS-1:0]   divide_half_in,
	input  wire logic [PHASE_W-1:0]             phase_step_in,
	input  wire logic                           phase_step_valid_in,
	input  wire logic                           phase_step_down_in,
	input  wire logic                           zero_delay_req_in,
	input  wire logic                           input_above_min_in,
	input  wire logic                           hitless_req_in,
	input  wire logic                           external_feedback_input_in,
	input  wire logic                           nvm_write_in,
	input  wire logic [NVM_W*NVM_WORDS-1:0]     nvm_image_in,
	input  wire logic [$clog2(NVM_WORDS)-1:0]   nvm_read_index_in,
	input  wire logic                           host_select_pin_in,
	input  wire logic                           spi_three_wire_in,
	input  wire logic [15:0]                    host_address_in,
	output logic [NUM_OUTPUTS-1:0]              clock_out_true_pin_out,
	output logic [NUM_OUTPUTS-1:0]              clock_out_comp_pin_out,
	output logic [NUM_OUTPUTS-1:0]              driver_on_out,
	output logic [2*NUM_OUTPUTS-1:0]            drive_strength_out,
	output logic [NVM_W-1:0]                    nvm_read_data_out,
	output logic [1:0]                          nvm_writes_used_out,
	output logic                                nvm_write_refused_out,
	output logic                                defaults_loaded_out,
	output logic                                clocks_running_out,
	output logic                                zero_delay_active_out,
	output logic                                internal_feedback_closed_out,
	output logic                                hitless_enabled_out,
	output logic                                host_is_i2c_out,
	output logic                                spi_shared_data_out,
	output logic [7:0]                          page_out,
	output logic [7:0]                          page_offset_out,
	output logic                                home_page_out,
	output logic [PHASE_W-1:0]                  phase_offset_out
);
	init_state_e state_reg;
	logic [NVM_W-1:0]       nvm_a_reg [NVM_WORDS];
	logic [NVM_W-1:0]       nvm_b_reg [NVM_WORDS];
	logic                   use_b_reg;
	logic [1:0]             writes_reg;
	logic [$clog2(NVM_WORDS)-1:0] load_idx_reg;
	logic [NVM_W-1:0]       shadow_reg [NVM_WORDS];
	logic                   oe_meta_reg;
	logic                   oe_sync_reg;
	logic [PHASE_W-1:0]     phase_reg;
	logic                   zd_reg;

	// Picks an output's slice out of a packed vector
	function automatic logic [DIV_W-1:0] div_of(input logic [DIV_W*NUM_OUTPUTS-1:0] v,
		input int i);
		div_of = v[i*DIV_W +: DIV_W];
	endfunction

	always_ff @(posedge ref_clk_in)
	begin
		if (rst_in)
		begin
			state_reg <= ST_RESET;
			load_idx_reg <= '0;
		end
		else
		begin
			unique case (state_reg)
				ST_RESET:
					state_reg <= ST_LOAD;
				ST_LOAD:
				begin
					load_idx_reg <= load_idx_reg + 1'b1;
					if (load_idx_reg == $clog2(NVM_WORDS)'(NVM_WORDS - 1))
						state_reg <= ST_DIVRST;
				end
				ST_DIVRST:
					state_reg <= ST_RUN;
				ST_RUN:
					state_reg <= ST_RUN;
				default:
					state_reg <= ST_RESET;
			endcase
		end
	end

	always_ff @(posedge ref_clk_in)
	begin
		if (rst_in)
		begin
			for (int k = 0; k < NVM_WORDS; k++)
				shadow_reg[k] <= '0;
		end
		else if (state_reg == ST_LOAD)
			shadow_reg[load_idx_reg] <= use_b_reg ? nvm_b_reg[load_idx_reg]
				: nvm_a_reg[load_idx_reg];
	end
	a_shadow_load: assert property (p_shadow_load) else $error("default word not loaded");
	property p_shadow_load;
		@(posedge ref_clk_in) disable iff (rst_in)
		(state_reg == ST_LOAD) |=> shadow_reg[$past(load_idx_reg)] ==
			$past(use_b_reg ? nvm_b_reg[load_idx_reg] : nvm_a_reg[load_idx_reg]);
	endproperty

	always_ff @(posedge ref_clk_in)
	begin
		if (rst_in)
		begin
			writes_reg <= 2'h0;
			use_b_reg <= 1'b0;
			nvm_write_refused_out <= 1'b0;
			for (int k = 0; k < NVM_WORDS; k++)
			begin
				nvm_a_reg[k] <= '0;
				nvm_b_reg[k] <= '0;
			end
		end
		else
		begin
			nvm_write_refused_out <= nvm_write_in && (writes_reg == NVM_MAX_WRITES);
			if (nvm_write_in && writes_reg != NVM_MAX_WRITES)
			begin
				writes_reg <= writes_reg + 2'h1;
				use_b_reg <= (writes_reg == 2'h1);
				for (int k = 0; k < NVM_WORDS; k++)
				begin
					if (writes_reg == 2'h0)
						nvm_a_reg[k] <= nvm_image_in[k*NVM_W +: NVM_W];
					else
						nvm_b_reg[k] <= nvm_image_in[k*NVM_W +: NVM_W];
				end
			end
		end
	end

	always_ff @(posedge ref_clk_in)
	begin
		if (rst_in)
			nvm_read_data_out <= '0;
		else
			nvm_read_data_out <= use_b_reg ? nvm_b_reg[nvm_read_index_in]
				: nvm_a_reg[nvm_read_index_in];
	end

	assign nvm_writes_used_out = writes_reg;
	assign defaults_loaded_out = (state_reg == ST_DIVRST) || (state_reg == ST_RUN);
	assign clocks_running_out = (state_reg == ST_RUN);

	always_ff @(posedge ref_clk_in)
	begin
		if (rst_in)
		begin
			oe_meta_reg <= 1'b1;
			oe_sync_reg <= 1'b1;
		end
		else
		begin
			oe_meta_reg <= global_output_disable_pin_in;
			oe_sync_reg <= oe_meta_reg;
		end
	end

	// phase steps by phase_step_in per valid cycle
	always_ff @(posedge ref_clk_in)
	begin
		if (rst_in)
			phase_reg <= '0;
		else if (phase_step_valid_in)
			phase_reg <= phase_step_down_in ? phase_reg - phase_step_in
				: phase_reg + phase_step_in;
	end
	assign phase_offset_out = phase_reg;

	always_ff @(posedge ref_clk_in)
	begin
		if (rst_in)
			zd_reg <= 1'b0;
		else
			zd_reg <= zero_delay_req_in && input_above_min_in;
	end
	assign zero_delay_active_out = zd_reg;
	assign internal_feedback_closed_out = !zd_reg;
	assign hitless_enabled_out = hitless_req_in && !zd_reg;

	assign host_is_i2c_out = (host_select_pin_in == HOST_I2C);
	assign spi_shared_data_out = !host_is_i2c_out && spi_three_wire_in;
	assign page_out = host_address_in[15:8];
	assign page_offset_out = host_address_in[7:0];
	assign home_page_out = (host_address_in[15:8] == HOME_PAGE);

	generate
		for (genvar g = 0; g < NUM_OUTPUTS; g++)
		begin : g_out
			logic [DIV_W-1:0] cnt_reg;
			logic             lvl_reg;
			logic             lvl_eff;
			logic             off_req;
			always_ff @(posedge ref_clk_in)
			begin
				if (rst_in || state_reg != ST_RUN)
				begin
					cnt_reg <= DIV_RESET;
					lvl_reg <= 1'b0;
				end
				else if (cnt_reg >= div_of(divide_half_in, g))
				begin
					cnt_reg <= DIV_RESET;
					lvl_reg <= ~lvl_reg;
				end
				else
					cnt_reg <= cnt_reg + 1'b1;
			end
			assign lvl_eff = zd_reg && (g == NUM_OUTPUTS - 1)
				? lvl_reg : lvl_reg;
			assign off_req = oe_sync_reg || out_disable_in[g] || state_reg != ST_RUN;
			out_driver_gate u_gate (
				.ref_clk_in             (ref_clk_in),
				.rst_in                 (rst_in),
				.clk_level_in           (lvl_eff),
				.disable_in             (off_req),
				.sync_disable_in        (sync_disable_in[g]),
				.park_high_in           (park_high_in[g]),
				.single_ended_in        (single_ended_in[g]),
				.invert_true_in         (invert_true_in[g]),
				.invert_comp_in         (invert_comp_in[g]),
				.drive_select_in        (single_ended_drive_select_in[2*g +: 2]),
				.rail_in                (driver_supply_rail_in[2*g +: 2]),
				.clock_out_true_pin_out (clock_out_true_pin_out[g]),
				.clock_out_comp_pin_out (clock_out_comp_pin_out[g]),
				.driver_on_out          (driver_on_out[g]),
				.drive_out              (drive_strength_out[2*g +: 2])
			);
			a_global_off: assert property (p_global_off) else $error("output on while disabled");
			property p_global_off;
				@(posedge ref_clk_in) disable iff (rst_in)
				(oe_sync_reg && !sync_disable_in[g]) |=> !driver_on_out[g];
			endproperty
			a_own_off: assert property (p_own_off) else $error("own disable ignored");
			property p_own_off;
				@(posedge ref_clk_in) disable iff (rst_in)
				(out_disable_in[g] && !sync_disable_in[g]) |=> !driver_on_out[g];
			endproperty
			a_div_rst: assert property (p_div_rst) else $error("divider not reset");
			property p_div_rst;
				@(posedge ref_clk_in) disable iff (rst_in)
				(state_reg == ST_DIVRST) |=> (cnt_reg == DIV_RESET && !lvl_reg);
			endproperty
		end
	endgenerate

	a_hitless: assert property (p_hitless) else $error("hitless on in zero delay");
	property p_hitless;
		@(posedge ref_clk_in) disable iff (rst_in)
		zd_reg |-> !hitless_enabled_out;
	endproperty
	a_zd_gate: assert property (p_zd_gate) else $error("zero delay below rate");
	property p_zd_gate;
		@(posedge ref_clk_in) disable iff (rst_in)
		!input_above_min_in |=> !zero_delay_active_out;
	endproperty
	a_nvm_cap: assert property (p_nvm_cap) else $error("third write accepted");
	property p_nvm_cap;
		@(posedge ref_clk_in) disable iff (rst_in)
		(nvm_write_in && writes_reg == NVM_MAX_WRITES) |=> $stable(writes_reg) ##0 nvm_write_refused_out;
	endproperty
	a_load_first: assert property (p_load_first) else $error("clocks before defaults");
	property p_load_first;
		@(posedge ref_clk_in) disable iff (rst_in)
		(state_reg == ST_LOAD) |-> !(|driver_on_out) || $past(state_reg) != ST_RESET;
	endproperty
	a_sync_pin: assert property (p_sync_pin) else $error("disable pin not synchronised");
	property p_sync_pin;
		@(posedge ref_clk_in) disable iff (rst_in)
		global_output_disable_pin_in ##1 global_output_disable_pin_in |=> oe_sync_reg;
	endproperty
endmodule

// ===== clk_receiver_model.sv
// Downstream clock receiver: watches output 0 for runts, loops the last output back.
// Assumes pins settle between system clock edges; parked level counts as idle.
`timescale 1ns/10ps
module clk_receiver_model
	import clk_out_pkg::*;
(
	input  wire logic                   ref_clk_in,
	input  wire logic [NUM_OUTPUTS-1:0] clock_out_true_pin_in,
	output logic                        external_feedback_input_out,
	output int                          runt_cnt_out
);
	int	high_len = 0;
	int	runt_cnt_reg = 0;
	assign external_feedback_input_out = clock_out_true_pin_in[NUM_OUTPUTS-1];
	assign runt_cnt_out = runt_cnt_reg;
	// High phase under two cycles is a runt
	always @(negedge ref_clk_in)
	begin
		if (clock_out_true_pin_in[0] === 1'b1)
			high_len <= high_len + 1;
		else
		begin
			if (high_len == 1)
				runt_cnt_reg <= runt_cnt_reg + 1;
			high_len <= 0;
		end
	end
endmodule

// ===== clock_output_gating_control_test.sv
// Self-checking bench for the clock output gating block.
// Assumes divide_half of 4 on every output; inputs change on falling edges.
`timescale 1ns/10ps
module clock_output_gating_control_test;
	import clk_out_pkg::*;
	logic	ref_clk_in, rst_in, global_output_disable_pin_in, phase_step_valid_in;
	logic	phase_step_down_in, zero_delay_req_in, input_above_min_in, hitless_req_in;
	logic	external_feedback_input_in, nvm_write_in, host_select_pin_in, spi_three_wire_in;
	logic	[3:0] out_disable_in, sync_disable_in, park_high_in, single_ended_in;
	logic	[3:0] invert_true_in, invert_comp_in, clock_out_true_pin_out, clock_out_comp_pin_out;
	logic	[3:0] driver_on_out;
	logic	[7:0] single_ended_drive_select_in, driver_supply_rail_in, drive_strength_out;
	logic	[31:0] divide_half_in;
	logic	[7:0] phase_step_in, page_out, page_offset_out, phase_offset_out, acc;
	logic	[127:0] nvm_image_in, img, kept;
	logic	[2:0] nvm_read_index_in;
	logic	[15:0] host_address_in, nvm_read_data_out;
	logic	[1:0] nvm_writes_used_out, e;
	logic	nvm_write_refused_out, defaults_loaded_out, clocks_running_out, z;
	logic	zero_delay_active_out, internal_feedback_closed_out, hitless_enabled_out;
	logic	host_is_i2c_out, spi_shared_data_out, home_page_out;
	logic	[31:0] exp_q[$];
	int	kind_q[$];
	int	error_cnt, checked, runt_cnt, i, j, r, c;
	integer	seed;
	event	chk_ev;

	clock_output_gating_control uut (.ref_clk_in(ref_clk_in), .rst_in(rst_in),
		.global_output_disable_pin_in(global_output_disable_pin_in),
		.out_disable_in(out_disable_in), .sync_disable_in(sync_disable_in),
		.park_high_in(park_high_in), .single_ended_in(single_ended_in),
		.invert_true_in(invert_true_in), .invert_comp_in(invert_comp_in),
		.single_ended_drive_select_in(single_ended_drive_select_in),
		.driver_supply_rail_in(driver_supply_rail_in), .divide_half_in(divide_half_in),
		.phase_step_in(phase_step_in), .phase_step_valid_in(phase_step_valid_in),
		.phase_step_down_in(phase_step_down_in), .zero_delay_req_in(zero_delay_req_in),
		.input_above_min_in(input_above_min_in), .hitless_req_in(hitless_req_in),
		.external_feedback_input_in(external_feedback_input_in),
		.nvm_write_in(nvm_write_in), .nvm_image_in(nvm_image_in),
		.nvm_read_index_in(nvm_read_index_in), .host_select_pin_in(host_select_pin_in),
		.spi_three_wire_in(spi_three_wire_in), .host_address_in(host_address_in),
		.clock_out_true_pin_out(clock_out_true_pin_out),
		.clock_out_comp_pin_out(clock_out_comp_pin_out), .driver_on_out(driver_on_out),
		.drive_strength_out(drive_strength_out), .nvm_read_data_out(nvm_read_data_out),
		.nvm_writes_used_out(nvm_writes_used_out),
		.nvm_write_refused_out(nvm_write_refused_out),
		.defaults_loaded_out(defaults_loaded_out), .clocks_running_out(clocks_running_out),
		.zero_delay_active_out(zero_delay_active_out),
		.internal_feedback_closed_out(internal_feedback_closed_out),
		.hitless_enabled_out(hitless_enabled_out), .host_is_i2c_out(host_is_i2c_out),
		.spi_shared_data_out(spi_shared_data_out), .page_out(page_out),
		.page_offset_out(page_offset_out), .home_page_out(home_page_out),
		.phase_offset_out(phase_offset_out));

	clk_receiver_model rx (.ref_clk_in(ref_clk_in), .clock_out_true_pin_in(clock_out_true_pin_out),
		.external_feedback_input_out(external_feedback_input_in), .runt_cnt_out(runt_cnt));

	initial
	begin
		ref_clk_in = 1'b0;
		forever #10 ref_clk_in = ~ref_clk_in;
	end

	function automatic logic [31:0] obs(input int k);
		case (k)
			0: obs = {28'h0, driver_on_out};
			1: obs = {24'h0, drive_strength_out};
			2: obs = {16'h0, nvm_read_data_out};
			3: obs = {29'h0, nvm_write_refused_out, nvm_writes_used_out};
			4: obs = {29'h0, zero_delay_active_out, internal_feedback_closed_out, hitless_enabled_out};
			5: obs = {13'h0, host_is_i2c_out, spi_shared_data_out, home_page_out, page_out,
				page_offset_out};
			6: obs = {24'h0, phase_offset_out};
			7: obs = {24'h0, clock_out_true_pin_out, clock_out_comp_pin_out};
			8: obs = {30'h0, defaults_loaded_out, clocks_running_out};
			9: obs = runt_cnt;
			10: obs = {28'h0, ~(clock_out_true_pin_out ^ clock_out_comp_pin_out)};
			11: obs = {31'h0, clock_out_true_pin_out == 4'h0 || clock_out_true_pin_out == 4'hf};
			default: obs = {28'h0, clock_out_true_pin_out & 4'b0101};
		endcase
	endfunction

	task automatic compare_val(input int k, input logic [31:0] x);
		checked++;
		if (obs(k) !== x)
		begin
			error_cnt++;
			$display("BAD %0t kind %0d got %h expected %h", $time, k, obs(k), x);
		end
	endtask

	// Results are compared the moment they are announced as present
	initial
		forever
		begin
			@(chk_ev);
			while (exp_q.size() > 0)
				compare_val(kind_q.pop_front(), exp_q.pop_front());
		end

	task automatic expect_val(input int k, input logic [31:0] x);
		kind_q.push_back(k);
		exp_q.push_back(x);
		->chk_ev;
		#1;
	endtask

	task automatic step(input int n);
		repeat (n) @(negedge ref_clk_in);
	endtask

	// Bounded wait for a level on output 0
	task automatic wait_pin(input logic lvl);
		int n;
		n = 0;
		while (clock_out_true_pin_out[0] !== lvl && n < 40)
		begin
			step(1);
			n++;
		end
	endtask

	task automatic nvm_store(input logic [127:0] d);
		nvm_image_in = d;
		nvm_write_in = 1'b1;
		step(1);
		nvm_write_in = 1'b0;
	endtask

	task automatic results;
		if (error_cnt == 0 && checked > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	initial
	begin
		#100000;
		error_cnt++;
		results;
	end

	initial
	begin
		seed = 32'ha20b3423;
		error_cnt = 0;
		checked = 0;
		rst_in = 1'b1;
		global_output_disable_pin_in = 1'b0;
		{out_disable_in, park_high_in, invert_true_in, invert_comp_in} = 16'h0;
		{sync_disable_in, single_ended_in} = 8'hff;
		single_ended_drive_select_in = 8'hff;
		driver_supply_rail_in = 8'h00;
		divide_half_in = {4{8'h04}};
		{phase_step_in, phase_step_valid_in, phase_step_down_in} = 10'h0;
		{zero_delay_req_in, input_above_min_in, hitless_req_in, nvm_write_in} = 4'h0;
		nvm_image_in = 128'h0;
		nvm_read_index_in = 3'h0;
		{host_select_pin_in, spi_three_wire_in} = 2'h2;
		host_address_in = 16'h0;
		step(4);
		expect_val(8, 32'h0);
		expect_val(7, 32'h0);
		expect_val(1, 32'hff);
		rst_in = 1'b0;
		i = 0;
		while (clocks_running_out !== 1'b1 && i < 40)
		begin
			step(1);
			i++;
		end
		expect_val(8, 32'h3);
		step(3);
		expect_val(0, 32'hf);
		for (i = 0; i < 6; i++)
		begin
			step(1);
			expect_val(11, 32'h1);
		end
		expect_val(10, 32'hf);
		{invert_true_in, invert_comp_in} = 8'h82;
		step(2);
		expect_val(10, 32'h5);
		{invert_true_in, invert_comp_in} = 8'h00;
		wait_pin(1'b0);
		wait_pin(1'b1);
		out_disable_in = 4'h1;
		step(1);
		expect_val(0, 32'hf);
		step(10);
		expect_val(0, 32'he);
		acc = 8'h00;
		for (i = 0; i < 4; i++)
		begin
			phase_step_in = 8'($random(seed));
			phase_step_down_in = i[0];
			phase_step_valid_in = 1'b1;
			acc = i[0] ? acc - phase_step_in : acc + phase_step_in;
			step(1);
			phase_step_valid_in = 1'b0;
			expect_val(6, {24'h0, acc});
			step(3);
		end
		expect_val(9, 32'h0);
		{out_disable_in, sync_disable_in} = 8'h0e;
		step(12);
		wait_pin(1'b0);
		wait_pin(1'b1);
		out_disable_in = 4'h1;
		step(2);
		expect_val(0, 32'he);
		{out_disable_in, sync_disable_in, park_high_in} = 12'h534;
		step(12);
		expect_val(0, 32'ha);
		expect_val(12, 32'h4);
		global_output_disable_pin_in = 1'b1;
		step(1);
		expect_val(0, 32'ha);
		step(12);
		expect_val(0, 32'h0);
		expect_val(12, 32'h4);
		global_output_disable_pin_in = 1'b0;
		out_disable_in = 4'h0;
		step(12);
		expect_val(0, 32'hf);
		for (r = 0; r < 3; r++)
			for (c = 0; c < 4; c++)
			begin
				driver_supply_rail_in[3:2] = r[1:0];
				single_ended_drive_select_in[3:2] = c[1:0];
				step(2);
				e = (c == 0) ? DRV_STRONG : c[1:0];
				e = (e == DRV_WEAK && r[1:0] == RAIL_1V8) ? DRV_MID : e;
				expect_val(1, {24'h0, 4'hf, e, 2'h3});
			end
		for (i = 0; i < 8; i++)
		begin
			{zero_delay_req_in, input_above_min_in, hitless_req_in} = i[2:0];
			step(2);
			z = i[2] & i[1];
			expect_val(4, {29'h0, z, ~z, i[0] & ~z});
		end
		for (j = 0; j < 3; j++)
		begin
			img = {$random(seed), $random(seed), $random(seed), $random(seed)};
			nvm_store(img);
			if (j < 2)
				kept = img;
			expect_val(3, (j == 2) ? 32'h6 : j + 1);
			step(1);
			expect_val(3, 32'h2 - (j == 0));
			for (i = 0; i < 8 && j < 2; i++)
			begin
				nvm_read_index_in = i[2:0];
				step(2);
				expect_val(2, {16'h0, img[i*16 +: 16]});
			end
		end
		step(2);
		expect_val(2, {16'h0, kept[127:112]});
		for (i = 0; i < 6; i++)
		begin
			{host_select_pin_in, spi_three_wire_in} = 2'($random(seed));
			host_address_in = (i == 0) ? 16'h0042 : 16'($random(seed));
			step(1);
			expect_val(5, {13'h0, host_select_pin_in,
				host_select_pin_in == HOST_SPI && spi_three_wire_in,
				host_address_in[15:8] == HOME_PAGE, host_address_in});
		end
		results;
	end
endmodule
